// *** logic/gpel_pkg.sv ***
// General-purpose event logic: register map, field positions, reset values.
// Assumes a 32-bit AXI4-Lite register bus; byte addresses are four times the index.
package gpel_pkg;
	// ****************************************
	// Register indices and address width
	// ****************************************
	localparam logic [7:0]  IDX_BRIDGE_EXT  = 8'ha6;
	localparam logic [7:0]  IDX_PM_DATA     = 8'ha7;
	localparam logic [7:0]  IDX_EV_STATUS   = 8'ha8;
	localparam logic [7:0]  IDX_EV_ENABLE   = 8'haa;
	localparam logic [7:0]  IDX_CTRL        = 8'hb8;
	localparam int          ADDR_W          = 10;
	// ****************************************
	// Fields
	// ****************************************
	localparam int          BIT_BPCC        = 7;
	localparam int          BIT_DEEP_SLEEP  = 6;
	localparam int          BIT_VIDEO       = 15;
	localparam int          BIT_POWER       = 11;
	localparam int          BIT_VPP12       = 8;
	localparam logic [15:0] EVENT_MASK      = 16'h891f;
	localparam logic [7:0]  BRIDGE_EXT_VAL  = 8'hc0;
	localparam logic [7:0]  PM_DATA_VAL     = 8'h00;
	localparam logic [15:0] EV_RESET        = 16'h0000;
	localparam int          N_INPUTS        = 5;
	localparam int          N_TERMS         = 7;
	localparam logic [1:0]  RESP_OKAY       = 2'b00;
	localparam logic [1:0]  RESP_SLVERR     = 2'b10;
endpackage

// *** logic/gpel_top.sv ***
// General-purpose event status/enable logic with AXI4-Lite register access.
// Assumes video, supply and vpp levels arrive synchronous to I_CLOCK; terminals are async.
`timescale 1ns/10ps
`default_nettype none

// Contract
// - Bridge extension bit 7 always reads one; writes ignored.
// - Bridge extension bit 6 always reads one.
// - Reserved bits of all registers read zero.
// - Power management data register always reads zero.
// - Writing one clears a status bit and its output; zero does nothing.
// - Status bits set regardless of enable bits.
// - Status bit 15 sets on any video-port enable change.
// - Status bit 11 sets on any socket supply or vpp change.
// - Status bit 8 sets on vpp request moving to or from 12 volts.
// - Status bits 4..0 set on level changes of their terminals.
// - Event output stays asserted until matching status or its enable cleared, or its terminal stops being general input.
// - Event output not gated by routing; pin enables follow terminals routed for event signalling.
// - Enable 15 lets video change raise the output.
// - Enable 11 lets socket power change raise the output.
// - Enable 8 lets 12 volt request change raise the output.
// - Enables 4..0 raise output only while terminal is general input.
module gpel_top (
	input  wire logic        I_CLOCK,
	input  wire logic        I_NRST,
	input  wire logic [9:0]  I_AWADDR,
	input  wire logic        I_AWVALID,
	output var  logic        O_AWREADY,
	input  wire logic [31:0] I_WDATA,
	input  wire logic [3:0]  I_WSTRB,
	input  wire logic        I_WVALID,
	output var  logic        O_WREADY,
	output var  logic [1:0]  O_BRESP,
	output var  logic        O_BVALID,
	input  wire logic        I_BREADY,
	input  wire logic [9:0]  I_ARADDR,
	input  wire logic        I_ARVALID,
	output var  logic        O_ARREADY,
	output var  logic [31:0] O_RDATA,
	output var  logic [1:0]  O_RRESP,
	output var  logic        O_RVALID,
	input  wire logic        I_RREADY,
	input  wire logic        I_VIDEO_PORT_ENABLE,
	input  wire logic [1:0]  I_SOCKET_VCC,
	input  wire logic [1:0]  I_SOCKET_VPP,
	input  wire logic [4:0]  I_MULTI_TERMINAL,
	input  wire logic [4:0]  I_TERMINAL_IS_INPUT,
	input  wire logic [6:0]  I_TERMINAL_IS_EVENT,
	input  wire logic        I_VPP_IS_12V,
	output var  logic        O_GENERAL_EVENT_OUTPUT,
	output var  logic [6:0]  O_GENERAL_EVENT_PIN_OE
);
	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		logic        aw_got;
		logic [9:0]  awaddr;
		logic        w_got;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
		logic [4:0]  sync1;
		logic [4:0]  sync2;
		logic [4:0]  term_prev;
		logic        video_prev;
		logic [3:0]  supply_prev;
		logic        vpp12_prev;
		logic        primed;
		logic [15:0] status;
		logic [15:0] enable;
		logic        event_out;
		logic [6:0]  pin_oe;
		logic        awready;
		logic        wready;
		logic        arready;
		logic [2:0]  term_ready;
	} gpel_state_type;

	// Readies come up high so a request may start at the first edge after reset
	localparam gpel_state_type STATE_RESET = '{
		awready: 1'b1,
		wready:  1'b1,
		arready: 1'b1,
		default: '0
	};

	gpel_state_type s_q;
	gpel_state_type s_d;

	logic [15:0] set_vec;
	logic [15:0] clr_vec;
	logic [15:0] live_enable;
	logic        wr_fire;
	logic [7:0]  wr_idx;
	logic [7:0]  rd_idx;
	logic        wr_hit;
	logic        rd_hit;
	logic [31:0] rd_word;

	always_comb begin
		s_d = s_q;
		set_vec = 16'h0000;
		clr_vec = 16'h0000;
		rd_word = 32'h0000_0000;
		// ****************************************
		// Synchronisers and change detection
		// ****************************************
		s_d.sync1 = I_MULTI_TERMINAL;
		s_d.sync2 = s_q.sync1;
		s_d.term_prev = s_q.sync2;
		s_d.video_prev = I_VIDEO_PORT_ENABLE;
		s_d.supply_prev = {I_SOCKET_VCC, I_SOCKET_VPP};
		s_d.vpp12_prev = I_VPP_IS_12V;
		s_d.primed = 1'b1;
		s_d.term_ready = {s_q.term_ready[1:0], 1'b1};
		// First cycle after reset only seeds the previous samples
		if (s_q.primed) begin
			set_vec[gpel_pkg::BIT_VIDEO] = I_VIDEO_PORT_ENABLE != s_q.video_prev;
			set_vec[gpel_pkg::BIT_POWER] = {I_SOCKET_VCC, I_SOCKET_VPP} != s_q.supply_prev;
			set_vec[gpel_pkg::BIT_VPP12] = I_VPP_IS_12V != s_q.vpp12_prev;
		end
		// Terminal compare waits for the sync chain to fill after reset,
		// else a pin held high would look like an edge; a pin edge after the
		// first sampling edge is still flagged once the chain fills
		if (s_q.term_ready[2]) begin
			set_vec[gpel_pkg::N_INPUTS-1:0] = s_q.sync2 ^ s_q.term_prev;
		end
		// ****************************************
		// AXI4-Lite write
		// ****************************************
		if (I_AWVALID && s_q.awready) begin
			s_d.aw_got = 1'b1;
			s_d.awaddr = I_AWADDR;
		end
		if (I_WVALID && s_q.wready) begin
			s_d.w_got = 1'b1;
			s_d.wdata = I_WDATA;
			s_d.wstrb = I_WSTRB;
		end
		wr_fire = s_q.aw_got && s_q.w_got && !s_q.bvalid;
		wr_idx = s_q.awaddr[gpel_pkg::ADDR_W-1:2];
		wr_hit = wr_idx == gpel_pkg::IDX_EV_STATUS || wr_idx == gpel_pkg::IDX_EV_ENABLE
			|| wr_idx == gpel_pkg::IDX_BRIDGE_EXT || wr_idx == gpel_pkg::IDX_PM_DATA;
		if (wr_fire) begin
			s_d.aw_got = 1'b0;
			s_d.w_got = 1'b0;
			s_d.bvalid = 1'b1;
			s_d.bresp = wr_hit ? gpel_pkg::RESP_OKAY : gpel_pkg::RESP_SLVERR;
			if (wr_idx == gpel_pkg::IDX_EV_STATUS) begin
				clr_vec = {s_q.wstrb[1] ? s_q.wdata[15:8] : 8'h00,
					s_q.wstrb[0] ? s_q.wdata[7:0] : 8'h00};
			end
			if (wr_idx == gpel_pkg::IDX_EV_ENABLE) begin
				if (s_q.wstrb[0]) begin
					s_d.enable[7:0] = s_q.wdata[7:0] & gpel_pkg::EVENT_MASK[7:0];
				end
				if (s_q.wstrb[1]) begin
					s_d.enable[15:8] = s_q.wdata[15:8] & gpel_pkg::EVENT_MASK[15:8];
				end
			end
		end
		if (s_q.bvalid && I_BREADY) begin
			s_d.bvalid = 1'b0;
		end
		// ****************************************
		// Status and event output
		// ****************************************
		// Set wins over a same-cycle clear, so no change is lost
		s_d.status = ((s_q.status & ~clr_vec) | set_vec) & gpel_pkg::EVENT_MASK;
		live_enable = s_q.enable & {11'h7ff, I_TERMINAL_IS_INPUT};
		s_d.event_out = |(s_d.status & live_enable);
		s_d.pin_oe = I_TERMINAL_IS_EVENT;
		// ****************************************
		// AXI4-Lite read
		// ****************************************
		rd_idx = I_ARADDR[gpel_pkg::ADDR_W-1:2];
		rd_hit = 1'b1;
		case (rd_idx)
			gpel_pkg::IDX_BRIDGE_EXT: rd_word = {24'h00_0000, gpel_pkg::BRIDGE_EXT_VAL};
			gpel_pkg::IDX_PM_DATA:    rd_word = {24'h00_0000, gpel_pkg::PM_DATA_VAL};
			gpel_pkg::IDX_EV_STATUS:  rd_word = {16'h0000, s_q.status};
			gpel_pkg::IDX_EV_ENABLE:  rd_word = {16'h0000, s_q.enable};
			gpel_pkg::IDX_CTRL:       rd_word = {25'h000_0000, I_TERMINAL_IS_EVENT};
			default:                  rd_hit = 1'b0;
		endcase
		if (I_ARVALID && s_q.arready) begin
			s_d.rvalid = 1'b1;
			s_d.rdata = rd_word;
			s_d.rresp = rd_hit ? gpel_pkg::RESP_OKAY : gpel_pkg::RESP_SLVERR;
		end else if (s_q.rvalid && I_RREADY) begin
			s_d.rvalid = 1'b0;
		end
		// Readies kept as flops of their own so every port leaves a register
		s_d.awready = !s_d.aw_got;
		s_d.wready = !s_d.w_got;
		s_d.arready = !s_d.rvalid;
	end

	always_ff @(posedge I_CLOCK or negedge I_NRST) begin
		if (!I_NRST) begin
			s_q <= STATE_RESET;
		end else begin
			s_q <= s_d;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign O_AWREADY = s_q.awready;
	assign O_WREADY = s_q.wready;
	assign O_BVALID = s_q.bvalid;
	assign O_BRESP = s_q.bresp;
	assign O_ARREADY = s_q.arready;
	assign O_RVALID = s_q.rvalid;
	assign O_RDATA = s_q.rdata;
	assign O_RRESP = s_q.rresp;
	assign O_GENERAL_EVENT_OUTPUT = s_q.event_out;
	assign O_GENERAL_EVENT_PIN_OE = s_q.pin_oe;

	// ****************************************
	// Checks
	// ****************************************
	sequence term_edge_s;
		s_q.term_ready[2] && (s_q.sync2[0] != s_q.term_prev[0]);
	endsequence

	sequence rd_take_s;
		I_ARVALID && O_ARREADY;
	endsequence

	sequence rd_wait_s;
		O_RVALID && !I_RREADY;
	endsequence

	sequence wr_wait_s;
		O_BVALID && !I_BREADY;
	endsequence

	sequence video_edge_s;
		s_q.primed && $changed(I_VIDEO_PORT_ENABLE);
	endsequence

	sequence power_edge_s;
		s_q.primed && $changed({I_SOCKET_VCC, I_SOCKET_VPP});
	endsequence

	sequence vpp_edge_s;
		s_q.primed && $changed(I_VPP_IS_12V);
	endsequence

	bridge_const_a: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
		(I_ARVALID && O_ARREADY && I_ARADDR[9:2] == gpel_pkg::IDX_BRIDGE_EXT)
		|=> (O_RDATA == 32'h0000_00c0)) else $error("bridge ext value wrong");
	deep_sleep_a: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
		(I_ARVALID && O_ARREADY && I_ARADDR[9:2] == gpel_pkg::IDX_BRIDGE_EXT)
		|=> O_RDATA[6]) else $error("deep sleep bit not one");
	reserved_zero_a: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
		((s_q.status | s_q.enable) & 16'h76e0) == 16'h0000) else $error("reserved bit set");
	pm_data_a: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
		(I_ARVALID && O_ARREADY && I_ARADDR[9:2] == gpel_pkg::IDX_PM_DATA)
		|=> O_RDATA == 32'h0000_0000) else $error("pm data nonzero");
	status_clear_a: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
		(clr_vec[15] && !set_vec[15]) |=> !s_q.status[15]) else $error("clear failed");
	input_set_a: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
		term_edge_s |=> s_q.status[0]) else $error("input change not flagged");
	video_set_a: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
		(s_q.primed && $changed(I_VIDEO_PORT_ENABLE)) |=> s_q.status[15])
		else $error("video change not flagged");
	output_hold_a: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
		(O_GENERAL_EVENT_OUTPUT && clr_vec == 16'h0000 && $stable(s_q.enable)
		&& $stable(I_TERMINAL_IS_INPUT)) |=> O_GENERAL_EVENT_OUTPUT)
		else $error("event output dropped");
	output_eq_a: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
		1'b1 |=> O_GENERAL_EVENT_OUTPUT == |(s_q.status & $past(s_q.enable
		& {11'h7ff, I_TERMINAL_IS_INPUT}))) else $error("event output mismatch");
	power_set_a: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
		power_edge_s |=> s_q.status[11]) else $error("power change not flagged");
	vpp_set_a: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
		vpp_edge_s |=> s_q.status[8]) else $error("vpp change not flagged");
	set_disabled_a: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
		(power_edge_s and (!s_q.enable[11])) |=> s_q.status[11])
		else $error("disabled event not flagged");
	status_keep_a: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
		(clr_vec == 16'h0000) |=> (s_q.status & $past(s_q.status)) == $past(s_q.status))
		else $error("status lost without clear");
	video_raise_a: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
		(video_edge_s and s_q.enable[15]) |=> O_GENERAL_EVENT_OUTPUT)
		else $error("video event not raised");
	power_raise_a: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
		(power_edge_s and s_q.enable[11]) |=> O_GENERAL_EVENT_OUTPUT)
		else $error("power event not raised");
	vpp_raise_a: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
		(vpp_edge_s and s_q.enable[8]) |=> O_GENERAL_EVENT_OUTPUT)
		else $error("vpp event not raised");
	term_gate_a: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
		(s_q.enable[15:5] == 11'h000 && I_TERMINAL_IS_INPUT == 5'h00)
		|=> !O_GENERAL_EVENT_OUTPUT) else $error("ungated terminal event");
	output_drop_a: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
		(set_vec == 16'h0000 && (s_q.status & ~clr_vec & live_enable) == 16'h0000)
		|=> !O_GENERAL_EVENT_OUTPUT) else $error("event output not dropped");
	pin_oe_a: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
		1'b1 |=> O_GENERAL_EVENT_PIN_OE == $past(I_TERMINAL_IS_EVENT))
		else $error("pin enable wrong");
	status_rsvd_a: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
		(rd_take_s and (I_ARADDR[9:2] == gpel_pkg::IDX_EV_STATUS))
		|=> (O_RDATA & 32'hffff_76e0) == 32'h0000_0000) else $error("status reserved set");
	read_answer_a: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
		rd_take_s |=> O_RVALID) else $error("read not answered");
	rvalid_hold_a: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
		rd_wait_s |=> O_RVALID && $stable(O_RDATA)) else $error("read data dropped");
	bvalid_hold_a: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
		wr_wait_s |=> O_BVALID && $stable(O_BRESP)) else $error("write response dropped");
endmodule

`default_nettype wire

// *** test/general_purpose_event_logic_bench.sv ***
// Bench for the event logic: AXI4-Lite master tasks and one task per scenario.
// Assumes a host model on the event output and byte address = index * 4.
`timescale 1ns/10ps
`default_nettype none
module general_purpose_event_logic_bench;
	logic clk = 0, nrst = 0, awv = 0, wv = 0, br = 0, arv = 0, rr = 0, vid = 0, v12 = 0;
	logic [9:0] awa = 0, ara = 0;
	logic [31:0] wd = 0, rd_d;
	logic [1:0] vcc = 0, vpp = 0, bresp, rresp;
	logic [4:0] term = 0, isin = 0;
	logic [6:0] isev = 0, oe;
	logic awr, wr_r, bv, arr, rv, evo;
	logic [31:0] rdat;
	int err_count = 0, num_checks = 0, wake;
	gpel_top dut (.I_CLOCK(clk), .I_NRST(nrst), .I_AWADDR(awa), .I_AWVALID(awv),
		.O_AWREADY(awr), .I_WDATA(wd), .I_WSTRB(4'hf), .I_WVALID(wv), .O_WREADY(wr_r),
		.O_BRESP(bresp), .O_BVALID(bv), .I_BREADY(br), .I_ARADDR(ara), .I_ARVALID(arv),
		.O_ARREADY(arr), .O_RDATA(rdat), .O_RRESP(rresp), .O_RVALID(rv), .I_RREADY(rr),
		.I_VIDEO_PORT_ENABLE(vid), .I_SOCKET_VCC(vcc), .I_SOCKET_VPP(vpp),
		.I_MULTI_TERMINAL(term), .I_TERMINAL_IS_INPUT(isin), .I_TERMINAL_IS_EVENT(isev),
		.I_VPP_IS_12V(v12), .O_GENERAL_EVENT_OUTPUT(evo), .O_GENERAL_EVENT_PIN_OE(oe));
	gpel_host_model host (.i_clock(clk), .i_nrst(nrst), .i_event(evo), .o_wakeups(wake));
	always #12.5 clk = ~clk;
	// ****************************************
	// Checking and bus tasks
	// ****************************************
	task automatic end_of_test();
		$display("checks %0d errors %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	task automatic chk(string n, logic [31:0] e, logic [31:0] s);
		num_checks++;
		if (s !== e) begin
			$display("BAD %s exp %h got %h", n, e, s);
			err_count++;
		end
	endtask
	// Ready sampled at the falling edge so the release lands right after the taking edge
	task automatic wr(logic [9:0] a, logic [31:0] d);
		logic ta, tw, tb;
		@(posedge clk);
		awa <= a; wd <= d; awv <= 1; wv <= 1; br <= 1;
		for (int i = 0; i < 50; i++) begin
			@(negedge clk);
			ta = awv && awr; tw = wv && wr_r; tb = bv;
			@(posedge clk);
			if (ta) awv <= 0;
			if (tw) wv <= 0;
			if (tb) begin
				br <= 0;
				chk("bresp", 2'b00, bresp);
				return;
			end
		end
		err_count++;
		end_of_test();
	endtask
	task automatic rd(logic [9:0] a, logic [31:0] e, logic [1:0] er = 2'b00);
		logic tr, ta;
		@(posedge clk);
		ara <= a; arv <= 1; rr <= 1;
		for (int i = 0; i < 50; i++) begin
			@(negedge clk);
			tr = rv; rd_d = rdat; ta = arv && arr;
			@(posedge clk);
			if (ta) arv <= 0;
			if (tr) begin
				rr <= 0;
				chk("rresp", er, rresp);
				if (er == 2'b00) chk("rdata", e, rd_d);
				return;
			end
		end
		err_count++;
		end_of_test();
	endtask
	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_regs();
		rd(10'h298, 32'h0000_00c0);
		wr(10'h298, 32'h0000_0000);
		rd(10'h298, 32'h0000_00c0);
		rd(10'h29c, 32'h0000_0000);
		rd(10'h2a0, 32'h0000_0000);
		rd(10'h3fc, 32'h0000_0000, 2'b10);
		wr(10'h2a8, 32'hffff_ffff);
		rd(10'h2a8, 32'h0000_891f);
	endtask
	task automatic t_disabled();
		wr(10'h2a8, 32'h0000_0000);
		vcc <= 2'b01;
		repeat (3) @(posedge clk);
		rd(10'h2a0, 32'h0000_0800);
		chk("evo off", 0, evo);
		wr(10'h2a0, 32'hffff_ffff);
		rd(10'h2a0, 32'h0000_0000);
	endtask
	task automatic t_video();
		wr(10'h2a8, 32'h0000_8000);
		vid <= 1;
		repeat (3) @(posedge clk);
		chk("evo video", 1, evo);
		wr(10'h2a0, 32'h0000_7fff);
		chk("evo held", 1, evo);
		rd(10'h2a0, 32'h0000_8000);
		wr(10'h2a0, 32'h0000_8000);
		chk("evo clr", 0, evo);
	endtask
	task automatic t_vpp();
		wr(10'h2a8, 32'h0000_0100);
		v12 <= 1; vpp <= 2'b10;
		repeat (3) @(posedge clk);
		chk("evo vpp", 1, evo);
		rd(10'h2a0, 32'h0000_0900);
		wr(10'h2a0, 32'h0000_0900);
		chk("evo vclr", 0, evo);
	endtask
	task automatic t_power();
		wr(10'h2a8, 32'h0000_0800);
		vcc <= 2'b10;
		repeat (3) @(posedge clk);
		chk("evo power", 1, evo);
		rd(10'h2a0, 32'h0000_0800);
		wr(10'h2a0, 32'h0000_0800);
		chk("evo pclr", 0, evo);
	endtask
	task automatic t_reset();
		nrst <= 0;
		repeat (3) @(posedge clk);
		chk("rst evo", 0, evo);
		chk("rst oe", 0, oe);
		nrst <= 1;
		repeat (2) @(posedge clk);
		rd(10'h2a0, 32'h0000_0000);
		rd(10'h2a8, 32'h0000_0000);
	endtask
	task automatic t_terms();
		isin <= 5'h1f;
		wr(10'h2a8, 32'h0000_001f);
		for (int i = 0; i < 5; i++) begin
			term[i] <= ~term[i];
			repeat (5) @(posedge clk);
			chk("evo term", 1, evo);
			rd(10'h2a0, 32'h1 << i);
			wr(10'h2a0, 32'hffff_ffff);
		end
		isin <= 5'h00;
		term[0] <= ~term[0];
		repeat (5) @(posedge clk);
		chk("evo gated", 0, evo);
		rd(10'h2a0, 32'h0000_0001);
		wr(10'h2a0, 32'hffff_ffff);
	endtask
	task automatic t_route();
		isev <= 7'h55;
		repeat (3) @(posedge clk);
		chk("pin oe", 7'h55, oe);
		rd(10'h2e0, 32'h0000_0055);
		chk("wakeups", 8, wake);
	endtask
	initial begin
		repeat (12) @(posedge clk);
		nrst <= 1;
		t_regs();
		t_disabled();
		t_video();
		t_vpp();
		t_power();
		t_terms();
		t_route();
		t_reset();
		end_of_test();
	end
endmodule
`default_nettype wire

// *** test/gpel_host_model.sv ***
// Host chipset event input: counts each wake-up seen on the event line.
// Assumes the event level is registered on the same clock.
`timescale 1ns/10ps
`default_nettype none
module gpel_host_model (
	input  wire logic i_clock,
	input  wire logic i_nrst,
	input  wire logic i_event,
	output var  int   o_wakeups
);
	logic prev_q;
	// Level input, so only rising edges mean a new wake-up
	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			prev_q <= 1'b0;
			o_wakeups <= 0;
		end else begin
			prev_q <= i_event;
			if (i_event && !prev_q) o_wakeups <= o_wakeups + 1;
		end
	end
endmodule
`default_nettype wire
